// >>> verification/control_partner.sv
// Purpose: machine control system and operator reset button driving the block
// Assumes: every change is made right after a rising edge of clk
// Notes:   press length is given in clock cycles so slow and prompt presses share one task
module control_partner
  import field_pair_pkg::*;
(
  input  wire logic clk,
  output logic [3:0] bankSel,
  output logic [6:0] pairSelA,
  output logic [6:0] pairSelB,
  output field_occ_t fieldOcc,
  output logic       resetButton
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bankSel     = 4'h0;
    pairSelA    = 7'h00;
    pairSelB    = 7'h00;
    fieldOcc    = 4'h0;
    resetButton = 1'b0;
  end

  // all indices move on one edge, so the block never sees half a selection
  task automatic select(input logic [3:0] b, input logic [6:0] a, input logic [6:0] bb);
    bankSel  <= b;
    pairSelA <= a;
    pairSelB <= bb;
    @(posedge clk);
  endtask : select

  task automatic occupy(input field_occ_t o);
    fieldOcc <= o;
    @(posedge clk);
  endtask : occupy

  // the bench picks the length; out of window lengths probe the refusal
  task automatic press(input int cycles);
    resetButton <= 1'b1;
    repeat (cycles) @(posedge clk);
    resetButton <= 1'b0;
    @(posedge clk);
  endtask : press
endmodule : control_partner

// >>> verification/testbench.sv
// Purpose: register and interlock tests of the field pair select block
// Assumes: one slave on the bus, hready taken from hreadyout
// Notes:   MS_CYCLES is 4, so one millisecond lasts four clocks
module testbench
  import field_pair_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MS    = 4;
  localparam int HOLD  = 120 * MS;
  localparam int OK    = 130 * MS;
  localparam int LIMIT = 40000;

  logic        clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [3:0]  bankSel;
  logic [6:0]  pairSelA;
  logic [6:0]  pairSelB;
  field_occ_t  fieldOcc;
  logic        resetButton;
  field_free_t fieldFree;
  logic        fault;
  logic [3:0]  activeBank;
  logic [6:0]  activePairA;
  logic [6:0]  activePairB;
  bank_cfg_t   activeCfg;
  int          nFail;
  int          nTests;
  int          cycles;

  assign hready = hreadyout;

  initial clk = 1'b0;
  always #10 clk = ~clk;

  field_pair_select_restart_interlock #(.MS_CYCLES(MS)) dut (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bankSel(bankSel),
    .pairSelA(pairSelA), .pairSelB(pairSelB), .fieldOcc(fieldOcc),
    .resetButton(resetButton), .fieldFree(fieldFree), .fault(fault),
    .activeBank(activeBank), .activePairA(activePairA),
    .activePairB(activePairB), .activeCfg(activeCfg)
  );

  control_partner ctl (
    .clk(clk), .bankSel(bankSel), .pairSelA(pairSelA), .pairSelB(pairSelB),
    .fieldOcc(fieldOcc), .resetButton(resetButton)
  );

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // no wait count is assumed: the cycle ceiling ends a stuck handshake
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0000_0000, rd);
    check(what, rd, exp);
    check("bus okay", 32'({hreadyout, hresp}), 32'h0000_0002);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nFail++;
      print_verdict();
    end
  end

  initial begin
    nFail   = 0;
    nTests  = 0;
    cycles  = 0;
    reset_n = 1'b0;
    hsel    = 1'b1;
    haddr   = 32'h0000_0000;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0000_0000;
    idle(4);
    reset_n <= 1'b1;
    rdchk("bank0 cfg", 32'h0000_0040, 32'h0000_0500);
    wr(32'h0000_0048, 32'h0003_70AD);
    rdchk("bank2 cfg", 32'h0000_0048, 32'h0003_70AD);
    rdchk("unmapped", 32'h0000_0200, 32'h0000_0000);
    wr(32'h0000_0008, 32'hFFFF_FFFF);
    rdchk("select ro", 32'h0000_0008, 32'h0000_0000);
    // a transfer meant for another slave must leave the bank alone
    hsel <= 1'b0;
    wr(32'h0000_0048, 32'h0000_0002);
    hsel <= 1'b1;
    rdchk("deselected wr", 32'h0000_0048, 32'h0003_70AD);
    check("free at start", 32'(fieldFree), 32'h0000_0003);
    ctl.occupy(4'h1);
    idle(2);
    check("prot A drop", 32'(fieldFree), 32'h0000_0002);
    ctl.occupy(4'h0);
    idle(2);
    check("auto restart", 32'(fieldFree), 32'h0000_0003);
    ctl.occupy(4'h2);
    idle(2);
    check("warn A drop", 32'(fieldFree), 32'h0000_0001);
    // switching onto an occupied pair: old output stands for the hold
    ctl.select(4'h0, 7'h05, 7'h00);
    ctl.occupy(4'h1);
    idle(HOLD - 40);
    check("occupied hold", 32'(fieldFree), 32'h0000_0003);
    idle(60);
    check("occupied off", 32'(fieldFree), 32'h0000_0002);
    ctl.occupy(4'h0);
    ctl.select(4'h0, 7'h0A, 7'h00);
    idle(3);
    check("bad pair fault", 32'(fault), 32'h0000_0001);
    check("bad pair free", 32'(fieldFree.funcAProtectFree), 32'h0000_0000);
    check("bad pair kept", 32'(activePairA), 32'h0000_0005);
    ctl.select(4'h0, 7'h05, 7'h00);
    ctl.press(100 * MS);
    idle(4);
    check("short press", 32'(fault), 32'h0000_0001);
    ctl.press(OK);
    idle(6);
    check("fault left", 32'(fault), 32'h0000_0000);
    check("free again", 32'(fieldFree), 32'h0000_0003);
    wr(32'h0000_0000, 32'h0000_0001);
    ctl.select(4'h0, 7'h63, 7'h00);
    idle(2);
    check("pair 99", 32'(activePairA), 32'h0000_0063);
    ctl.select(4'h0, 7'h03, 7'h07);
    wr(32'h0000_0000, 32'h0000_0002);
    idle(2);
    check("dual A", 32'(activePairA), 32'h0000_0003);
    check("dual B", 32'(activePairB), 32'h0000_0007);
    ctl.select(4'h0, 7'h03, 7'h09);
    idle(2);
    check("dual A kept", 32'(activePairA), 32'h0000_0003);
    check("dual B moved", 32'(activePairB), 32'h0000_0009);
    idle(HOLD + 20);
    ctl.occupy(4'h4);
    idle(2);
    check("prot B only", 32'(fieldFree), 32'h0000_000B);
    ctl.occupy(4'h0);
    wr(32'h0000_0000, 32'h0000_000B);
    ctl.select(4'h0, 7'h2D, 7'h09);
    idle(2);
    check("four B follows", 32'(activePairB), 32'h0000_002D);
    idle(HOLD + 20);
    ctl.occupy(4'h1);
    idle(2);
    check("four prot A", 32'(fieldFree), 32'h0000_000E);
    ctl.occupy(4'h0);
    ctl.select(4'h0, 7'h01, 7'h00);
    wr(32'h0000_0000, 32'h0000_0004);
    idle(HOLD + 20);
    ctl.select(4'h2, 7'h01, 7'h00);
    idle(3);
    check("bank 2", 32'(activeBank), 32'h0000_0002);
    check("bank 2 cfg", 32'(activeCfg), 32'h0003_70AD);
    check("bank locked", 32'(fieldFree), 32'h0000_0002);
    ctl.press(4100 * MS);
    idle(4);
    check("long press", 32'(fieldFree), 32'h0000_0002);
    ctl.press(OK);
    idle(6);
    check("bank released", 32'(fieldFree), 32'h0000_0003);
    ctl.occupy(4'h1);
    idle(2);
    check("lock bank drop", 32'(fieldFree), 32'h0000_0002);
    ctl.occupy(4'h0);
    idle(2);
    check("lock bank restart", 32'(fieldFree), 32'h0000_0003);
    wr(32'h0000_0000, 32'h0000_0005);
    ctl.select(4'h4, 7'h09, 7'h00);
    idle(3);
    check("multi2 bank", 32'(activeBank), 32'h0000_0004);
    check("multi2 B", 32'(activePairB), 32'h0000_0009);
    ctl.select(4'h5, 7'h09, 7'h00);
    idle(3);
    check("bank 5 fault", 32'(fault), 32'h0000_0001);
    print_verdict();
  end
endmodule : testbench

// >>> verilog/field_pair_defs.svh
// Purpose: named offsets, limits and times of the field pair select block
// Assumes: 50 MHz clock, byte addresses on the register bus
// Notes:   all times are kept in milliseconds and counted on a 1 ms tick
`ifndef FIELD_PAIR_DEFS_SVH
`define FIELD_PAIR_DEFS_SVH

`define CLK_FREQ_HZ      50_000_000
`define MS_PER_S         1000

// reset button hold window: 0.12 s and 4 s
`define PRESS_MIN_MS     13'h0078
`define PRESS_MAX_MS     13'h0FA0
// extra delay added to the response time on every pair change: 40 ms
`define SYNC_DELAY_MS    9'h028

`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define REG_SELECT       12'h008
`define REG_BANK_BASE    12'h040
`define REG_BANK_LAST    12'h064
`define HTRANS_ACTIVE    1
`define HSIZE_WORD       3'h2
`define WORD_SHIFT       2

`define NUM_BANKS        10
`define PAIRS_STD        7'h0A
`define PAIRS_FOUR       7'h32
`define PAIRS_LARGE      7'h64
`define BANKS_MULTI_ONE  4'hA
`define BANKS_MULTI_TWO  4'h5
`define BANK_ZERO        4'h0
`define PAIR_ZERO        7'h00
`define RESP_DEF_MS      8'h50

`endif

// >>> verilog/field_pair_pkg.sv
// Purpose: types shared by the field pair select block and its bench
// Assumes: nothing beyond the constants header
// Notes:   register words are packed structs, first member in the high bits of the word
package field_pair_pkg;

  typedef enum logic [2:0] {
    MODE_SINGLE     = 3'h0,
    MODE_SINGLE100  = 3'h1,
    MODE_DUAL       = 3'h2,
    MODE_FOUR       = 3'h3,
    MODE_MULTI_ONE  = 3'h4,
    MODE_MULTI_TWO  = 3'h5
  } mode_t;

  typedef enum logic [2:0] {
    RES_30MM  = 3'h0,
    RES_40MM  = 3'h1,
    RES_50MM  = 3'h2,
    RES_60MM  = 3'h3,
    RES_70MM  = 3'h4,
    RES_150MM = 3'h5
  } res_t;

  // gray along locked -> run -> fault
  typedef enum logic [1:0] {
    ST_LOCKED = 2'h0,
    ST_RUN    = 2'h1,
    ST_FAULT  = 2'h3
  } state_t;

  typedef struct packed {
    logic [7:0] vehicleSpeedLimit;
    logic [7:0] responseMs;
    logic       startupLock;
    res_t       resolution;
  } bank_cfg_t;

  typedef struct packed {
    logic  fourProtect;
    mode_t mode;
  } ctrl_t;

  typedef struct packed {
    logic funcBWarnFree;
    logic funcBProtectFree;
    logic funcAWarnFree;
    logic funcAProtectFree;
  } field_free_t;

  typedef struct packed {
    logic warnB;
    logic protB;
    logic warnA;
    logic protA;
  } field_occ_t;

  typedef struct packed {
    logic        manualNeed;
    logic        holdActive;
    logic        fault;
    state_t      state;
    field_free_t free;
  } status_t;

endpackage : field_pair_pkg

// >>> verilog/field_pair_select_restart_interlock.sv
// Purpose: field pair selection, clear outputs and start interlock of a scanner
// Assumes: selection, occupancy and reset button inputs are synchronous to clk
// Notes:   zero wait state AHB-Lite slave; button press measured in 1 ms ticks
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`include "field_pair_defs.svh"

module field_pair_select_restart_interlock
  import field_pair_pkg::*;
#(
  parameter int MS_CYCLES = `CLK_FREQ_HZ / `MS_PER_S
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [3:0]  bankSel,
  input  wire logic [6:0]  pairSelA,
  input  wire logic [6:0]  pairSelB,
  input  wire field_occ_t  fieldOcc,
  input  wire logic        resetButton,
  output field_free_t      fieldFree,
  output logic             fault,
  output logic [3:0]       activeBank,
  output logic [6:0]       activePairA,
  output logic [6:0]       activePairB,
  output bank_cfg_t        activeCfg
);

  ctrl_t       ctrl_q;
  bank_cfg_t   bankCfg_q [`NUM_BANKS];
  logic        wrPend_q;
  logic [11:0] wrAddr_q;
  logic [15:0] msCnt_q;
  logic        msTick;
  logic [3:0]  effBank;
  logic [6:0]  effPairB;
  logic        selValid;
  logic        bUsed;
  logic        pairChange;
  logic        bankChange;
  logic [8:0]  holdMs_q;
  logic        holdActive;
  logic [12:0] pressMs_q;
  logic        btnPrev_q;
  logic        pressValid;
  logic        manualNeed_q;
  state_t      state_q;
  logic        run;
  logic        warnIsProt;
  logic        addrPhase;
  logic [31:0] rdMux;
  field_free_t free_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ---------------- register bus ----------------
  assign addrPhase = hsel && hready && htrans[`HTRANS_ACTIVE] && (hsize == `HSIZE_WORD);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 12'h000;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[11:0];
    end
  end

  // the slave never stalls, so hreadyout and hresp are constant flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (haddr[31:12] != 20'h0_0000) begin
      rdMux = 32'h0000_0000;
    end else if (haddr[11:0] == `REG_CTRL) begin
      rdMux = 32'(ctrl_q);
    end else if (haddr[11:0] == `REG_STATUS) begin
      rdMux = 32'({manualNeed_q, holdActive, fault, state_q, fieldFree});
    end else if (haddr[11:0] == `REG_SELECT) begin
      rdMux = 32'({activePairB, activePairA, activeBank});
    end else if (haddr[11:0] >= `REG_BANK_BASE && haddr[11:0] <= `REG_BANK_LAST && haddr[1:0] == 2'h0) begin
      rdMux = 32'(bankCfg_q[4'((haddr[11:0] - `REG_BANK_BASE) >> `WORD_SHIFT)]);
    end
  end

  // read data is launched at the address phase edge so it stands in the data phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdMux;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= ctrl_t'({1'b0, MODE_SINGLE});
    end else if (wrPend_q && wrAddr_q == `REG_CTRL) begin
      ctrl_q <= ctrl_t'(hwdata[$bits(ctrl_t)-1:0]);
    end
  end

  // one settings word per bank: resolution, speed, response time, start-up
  for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
    localparam logic [11:0] BankAddr = 12'(`REG_BANK_BASE + (b << `WORD_SHIFT));
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        bankCfg_q[b] <= bank_cfg_t'({8'h00, `RESP_DEF_MS, 1'b0, RES_30MM});
      end else if (wrPend_q && wrAddr_q == BankAddr) begin
        bankCfg_q[b] <= bank_cfg_t'(hwdata[$bits(bank_cfg_t)-1:0]);
      end
    end
  end

  // ---------------- millisecond tick ----------------
  assign msTick = (msCnt_q == 16'(MS_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      msCnt_q <= 16'h0000;
    end else if (msTick) begin
      msCnt_q <= 16'h0000;
    end else begin
      msCnt_q <= msCnt_q + 16'h0001;
    end
  end

  // ---------------- field pair selection ----------------
  assign effBank = (ctrl_q.mode == MODE_MULTI_ONE || ctrl_q.mode == MODE_MULTI_TWO) ? bankSel : `BANK_ZERO;
  assign bUsed   = (ctrl_q.mode == MODE_DUAL || ctrl_q.mode == MODE_FOUR || ctrl_q.mode == MODE_MULTI_TWO);

  always_comb begin
    effPairB = `PAIR_ZERO;
    case (ctrl_q.mode)
      MODE_DUAL:      effPairB = pairSelB;
      MODE_FOUR:      effPairB = pairSelA;
      MODE_MULTI_TWO: effPairB = pairSelA;
      default:        effPairB = `PAIR_ZERO;
    endcase
  end

  // selections outside the mode's range count as a broken switching rule
  always_comb begin
    selValid = 1'b0;
    case (ctrl_q.mode)
      MODE_SINGLE:    selValid = pairSelA < `PAIRS_STD;
      MODE_SINGLE100: selValid = pairSelA < `PAIRS_LARGE;
      MODE_DUAL:      selValid = pairSelA < `PAIRS_STD && pairSelB < `PAIRS_STD;
      MODE_FOUR:      selValid = pairSelA < `PAIRS_FOUR;
      MODE_MULTI_ONE: selValid = bankSel < `BANKS_MULTI_ONE && pairSelA < `PAIRS_STD;
      MODE_MULTI_TWO: selValid = bankSel < `BANKS_MULTI_TWO && pairSelA < `PAIRS_STD;
      default:        selValid = 1'b0;
    endcase
  end

  assign pairChange = selValid && (effBank != activeBank || pairSelA != activePairA || effPairB != activePairB);
  assign bankChange = selValid && (ctrl_q.mode == MODE_MULTI_ONE) && (effBank != activeBank);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      activeBank  <= `BANK_ZERO;
      activePairA <= `PAIR_ZERO;
      activePairB <= `PAIR_ZERO;
    end else if (selValid) begin
      activeBank  <= effBank;
      activePairA <= pairSelA;
      activePairB <= effPairB;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      activeCfg <= bank_cfg_t'({8'h00, `RESP_DEF_MS, 1'b0, RES_30MM});
    end else begin
      activeCfg <= bankCfg_q[activeBank];
    end
  end

  // ---------------- changeover delay ----------------
  // the old bank's response time applies: the new bank's settings land a cycle later
  assign holdActive = (holdMs_q != 9'h000);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      holdMs_q <= 9'h000;
    end else if (pairChange) begin
      holdMs_q <= {1'b0, activeCfg.responseMs} + `SYNC_DELAY_MS;
    end else if (msTick && holdActive) begin
      holdMs_q <= holdMs_q - 9'h001;
    end
  end

  // ---------------- reset button timing ----------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      btnPrev_q <= 1'b0;
      pressMs_q <= 13'h0000;
    end else begin
      btnPrev_q <= resetButton;
      if (!resetButton) begin
        pressMs_q <= 13'h0000;
      end else if (msTick && pressMs_q <= `PRESS_MAX_MS) begin
        pressMs_q <= pressMs_q + 13'h0001;
      end
    end
  end

  // accepted only on release, so an over-long hold is never honoured
  assign pressValid = btnPrev_q && !resetButton && pressMs_q >= `PRESS_MIN_MS && pressMs_q <= `PRESS_MAX_MS;

  // ---------------- interlock state ----------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      manualNeed_q <= 1'b0;
    end else if (bankChange) begin
      manualNeed_q <= 1'b1;
    end else if (pressValid) begin
      manualNeed_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_LOCKED;
    end else begin
      case (state_q)
        ST_LOCKED: begin
          if (!selValid) begin
            state_q <= ST_FAULT;
          end else if (bankChange) begin
            state_q <= ST_LOCKED;
          end else if (pressValid) begin
            state_q <= ST_RUN;
          end else if (!activeCfg.startupLock && !manualNeed_q) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!selValid) begin
            state_q <= ST_FAULT;
          end else if (bankChange) begin
            state_q <= ST_LOCKED;
          end
        end
        ST_FAULT: begin
          if (pressValid && selValid) begin
            state_q <= ST_LOCKED;
          end
        end
        default: state_q <= ST_FAULT;
      endcase
    end
  end

  // ---------------- clear outputs ----------------
  assign run        = (state_q == ST_RUN);
  assign warnIsProt = ctrl_q.fourProtect && (ctrl_q.mode == MODE_FOUR);

  // protective outputs keep the old result during a changeover and drop when leaving run; warning outputs only with fourProtect in four-field mode
  always_comb begin
    free_d.funcAProtectFree = run && (holdActive ? fieldFree.funcAProtectFree : !fieldOcc.protA);
    free_d.funcBProtectFree = run && bUsed && (holdActive ? fieldFree.funcBProtectFree : !fieldOcc.protB);
    free_d.funcAWarnFree    = (run || !warnIsProt) && !fieldOcc.warnA;
    free_d.funcBWarnFree    = (run || !warnIsProt) && bUsed && !fieldOcc.warnB;
    if (warnIsProt && holdActive) begin
      free_d.funcAWarnFree = run && fieldFree.funcAWarnFree;
      free_d.funcBWarnFree = run && fieldFree.funcBWarnFree;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fieldFree <= field_free_t'(4'h0);
      fault     <= 1'b0;
    end else begin
      fieldFree <= free_d;
      fault     <= (state_q == ST_FAULT);
    end
  end

  // ---------------- checks ----------------
  chk_b_group_off:    assert property (!bUsed ##1 !bUsed |-> !fieldFree.funcBProtectFree && !fieldFree.funcBWarnFree)
    else $error("function B output active in a single-function mode");
  chk_four_follow:    assert property (selValid && ctrl_q.mode == MODE_FOUR |=> activePairB == $past(pairSelA))
    else $error("four-field mode B pair does not follow A");
  chk_dual_indep:     assert property (selValid && ctrl_q.mode == MODE_DUAL |=> activePairB == $past(pairSelB))
    else $error("dual mode B pair not taken from its own input");
  chk_intrusion_off:  assert property (run && !holdActive && fieldOcc.protA |=> !fieldFree.funcAProtectFree)
    else $error("protective A output not off after intrusion");
  chk_auto_restart:   assert property (run && !holdActive && !fieldOcc.protA |=> fieldFree.funcAProtectFree)
    else $error("protective A output not restored when field clear");
  chk_fault_off:      assert property (
    state_q == ST_RUN && !selValid
    |=> state_q == ST_FAULT ##1 fault && !fieldFree.funcAProtectFree && !fieldFree.funcBProtectFree)
    else $error("illegal selection did not fault");
  chk_bank_lock:      assert property (bankChange |=> state_q != ST_RUN && manualNeed_q ##1 !fieldFree.funcAProtectFree)
    else $error("bank change did not lock outputs");
  chk_auto_start:     assert property (state_q == ST_LOCKED && selValid && !bankChange && !activeCfg.startupLock && !manualNeed_q |=> run)
    else $error("automatic start did not enable outputs");
  chk_interlock_hold: assert property (state_q == ST_LOCKED && !pressValid && (activeCfg.startupLock || manualNeed_q) |=> !run)
    else $error("interlock released without a valid press");
  chk_press_window:   assert property (pressValid |-> $past(resetButton) && pressMs_q >= `PRESS_MIN_MS && pressMs_q <= `PRESS_MAX_MS)
    else $error("press accepted outside hold window");
  chk_switch_delay:   assert property (pairChange |=> holdMs_q == {1'b0, $past(activeCfg.responseMs)} + `SYNC_DELAY_MS)
    else $error("changeover delay not loaded");

  // selection follows the mode's range, its pairing of A and B and the bank input
  chk_large_range:    assert property (
    ctrl_q.mode == MODE_SINGLE100 && pairSelA < `PAIRS_LARGE |=> activePairA == $past(pairSelA))
    else $error("large single mode pair not taken");
  chk_multi_follow:   assert property (
    selValid && ctrl_q.mode == MODE_MULTI_TWO
    |=> activePairB == $past(pairSelA) && activeBank == $past(bankSel))
    else $error("dual multi-bank B pair or bank wrong");
  chk_bank_settle:    assert property (
    selValid && ctrl_q.mode == MODE_MULTI_ONE |=> activeBank == $past(bankSel))
    else $error("multi-bank selection not taken");

  // clear outputs, changeover and interlock
  chk_prot_b_own:     assert property (
    run && !holdActive && bUsed && fieldOcc.protB && !fieldOcc.protA
    |=> !fieldFree.funcBProtectFree && fieldFree.funcAProtectFree)
    else $error("protective B intrusion not reported on B alone");
  chk_warn_follow:    assert property (
    !warnIsProt |=> fieldFree.funcAWarnFree == !$past(fieldOcc.warnA))
    else $error("warning A output does not follow its field");
  chk_hold_frozen:    assert property (
    holdActive && run |=> fieldFree.funcAProtectFree == $past(fieldFree.funcAProtectFree))
    else $error("protective A output moved during changeover");
  chk_valid_release:  assert property (
    state_q == ST_LOCKED && selValid && !bankChange && pressValid |=> run)
    else $error("valid press did not release the outputs");
  chk_fault_exit:     assert property (
    state_q == ST_FAULT && !(pressValid && selValid) |=> state_q == ST_FAULT)
    else $error("fault left without a valid press");


  cov_bank_change:  cover property (bankChange ##1 state_q == ST_LOCKED);
  cov_valid_press:  cover property (pressValid ##1 run);
  cov_fault:        cover property (state_q == ST_FAULT);
  cov_switch_hold:  cover property (pairChange && fieldOcc.protA ##1 holdActive);
  cov_long_press:   cover property (btnPrev_q && !resetButton && pressMs_q > `PRESS_MAX_MS);

endmodule : field_pair_select_restart_interlock
